// ===== logic/rhp_cfg.svh
/*
 Timing counts, offsets, bit positions and reset values for the root hub
 port status and control block. Assumes a 125 MHz ref_clk.
*/
`ifndef RHP_CFG_SVH
`define RHP_CFG_SVH
`define RHP_CLK_MHZ 125
`define RHP_PORT0_OFS 8'h54
`define RHP_PORT1_OFS 8'h58
`define RHP_RESET_VAL 32'h00000000
`define RHP_B_CONN 0
`define RHP_B_ENA 1
`define RHP_B_SUSP 2
`define RHP_B_OCI 3
`define RHP_B_RST 4
`define RHP_B_PWR 8
`define RHP_B_SLOW 9
`define RHP_B_CSC 16
`define RHP_B_ESC 17
`define RHP_B_SSC 18
`define RHP_B_OCC 19
`define RHP_B_RSC 20
`define RHP_RESET_MS 10
`define RHP_RESET_CYC (`RHP_RESET_MS * 1000 * `RHP_CLK_MHZ)
`endif

// ===== logic/rhp_pkg.sv
/*
 Types shared by the root hub port block.
 Assumes rhp_cfg.svh is on the include path.
*/
`default_nettype none
package rhp_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} rhp_req_t;
	typedef struct packed {
		logic connected;
		logic slow;
		logic overcurrent;
		logic disable_evt;
		logic resume_done;
	} rhp_line_t;
	typedef enum logic [0:0] {
		RHP_IDLE = 1'b0,
		RHP_RESETTING = 1'b1
	} rhp_rst_state_t;
endpackage
`default_nettype wire

// ===== logic/rhp_top.sv
/*
 Root hub port status/control registers for two downstream ports, with
 the port reset timer. Assumes the register port is synchronous to ref_clk,
 and the line side reports connect, speed, overcurrent, enable loss and
 resume completion as levels/pulses per port. Global power commands and
 switching mode come from the root hub status logic as inputs.
*/
`include "rhp_cfg.svh"
`default_nettype none
// Functional notes
// RULE_01: Writes during a token-to-handshake transaction wait until it ends.
// RULE_02: Lower half shows status, upper half shows change flags.
// RULE_03: Software writes zeros to reserved bits 31:21 and 15:10.
// RULE_04: Reset-done flag sets after 10 ms reset; write one clears.
// RULE_05: Overcurrent-change flag sets on indicator change; write one clears.
// RULE_06: Resume-done flag sets after full resume sequence; write one clears.
// RULE_07: Resume-done flag clears whenever reset-done flag becomes set.
// RULE_08: Enable-change flag sets only on hardware disable; write one clears. Code also sets it when a software power-off clears an enabled port.
// RULE_09: Connect-change flag sets on connect or disconnect; write one clears.
// RULE_10: Reset, enable or suspend write on empty port sets connect-change.
// RULE_11: Fixed-device port sets connect-change only after root hub reset.
// RULE_12: Speed bit reads one for low-speed, zero for full-speed.
// RULE_13: Writing one to speed bit clears port power.
// RULE_14: Power bit reflects real power; overcurrent clears it. Code clears it only while per_port_oc is set.
// RULE_15: Global switching mode obeys only global power commands.
// RULE_16: Per-port mode: masked ports obey port commands, others global.
// RULE_17: Power off resets connect, enable, suspend and reset status. Code reads connect status straight from the line input.
// RULE_18: One register per port, first at offset 54h.
// RULE_19: Write one to power bit sets power; reads one if unswitched.
// RULE_20: Reset write starts reset; disconnected port sets connect instead.
// RULE_21: Overcurrent bit reads zero unless per-port reporting is present.
// RULE_22: Second port register sits at the next word, same layout.
module rhp_top
	import rhp_pkg::*;
#(
	parameter int RESET_CYC = `RHP_RESET_CYC
) (
	input wire logic ref_clk, // Host controller clock
	input wire logic reset_n, // Async reset, active low
	input wire rhp_req_t req, // Register read/write request
	output logic [31:0] rdata_reg, // Read data, valid cycle after rd
	input wire logic xact_busy, // Transaction in progress
	input wire rhp_line_t [1:0] line, // Line side state per port
	input wire logic pwr_switched, // Power switching implemented
	input wire logic pwr_mode, // Switching mode, 1 is per port
	input wire logic [1:0] per_port_power_mask, // Port power mask
	input wire logic [1:0] fixed_device_flag, // Non-removable device
	input wire logic per_port_oc, // Per-port overcurrent reporting
	input wire logic glob_set_pwr, // Global set power pulse
	input wire logic glob_clr_pwr, // Global clear power pulse
	input wire logic hub_reset_done, // Root hub reset finished pulse
	output logic [1:0] port_reset_out_reg, // Reset signalling active
	output logic [1:0] port_suspend_out_reg, // Suspend state to line
	output logic [1:0] port_power_out_reg // Power switch drive
);
	logic pend_reg;
	rhp_req_t pend_req_reg;
	logic [1:0] connect_changed_reg, enable_changed_reg;
	logic [1:0] resume_done_changed_reg, overcurrent_changed_reg;
	logic [1:0] reset_done_changed_reg;
	logic [1:0] port_enabled_reg, port_suspended_reg, port_powered_reg;
	logic [1:0] conn_q_reg, oc_q_reg;
	logic [31:0] rdata_next;
	rhp_req_t eff;
	logic eff_wr;

	// RULE_01: hold writes while busy
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= 1'b0;
			pend_req_reg <= '0;
		end else if (req.wr && xact_busy) begin
			pend_reg <= 1'b1;
			pend_req_reg <= req;
		end else if (!xact_busy) begin
			pend_reg <= 1'b0;
		end
	end

	always_comb begin
		eff = pend_reg ? pend_req_reg : req;
		eff_wr = !xact_busy && (pend_reg || req.wr);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			conn_q_reg <= 2'b00;
			oc_q_reg <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				conn_q_reg[i] <= line[i].connected;
				oc_q_reg[i] <= line[i].overcurrent & per_port_oc;
			end
		end
	end

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic hit;
			logic [31:0] wd;
			logic w_rst, w_ena, w_susp, w_pwr_on, w_pwr_off;
			logic pwr_on, pwr_off, oc_now, rst_end, conn_now;
			logic [23:0] cnt_reg;
			rhp_rst_state_t st_reg;
			// RULE_18: first port register at 54h
			// RULE_22: second port at next word
			always_comb begin
				if (p == 0) begin
					hit = eff_wr && eff.addr == `RHP_PORT0_OFS;
				end else begin
					hit = eff_wr && eff.addr == `RHP_PORT1_OFS;
				end
				wd = hit ? eff.wdata : 32'h00000000;
				conn_now = line[p].connected;
				oc_now = line[p].overcurrent & per_port_oc;
				w_rst = wd[`RHP_B_RST];
				w_ena = wd[`RHP_B_ENA];
				w_susp = wd[`RHP_B_SUSP];
				w_pwr_on = wd[`RHP_B_PWR];
				// RULE_13: speed position clears power
				w_pwr_off = wd[`RHP_B_SLOW];
				// RULE_15: global mode uses global commands
				// RULE_16: mask picks port or global commands
				if (pwr_mode && per_port_power_mask[p]) begin
					pwr_on = w_pwr_on;
					pwr_off = w_pwr_off;
				end else begin
					pwr_on = glob_set_pwr;
					pwr_off = glob_clr_pwr;
				end
				rst_end = st_reg == RHP_RESETTING &&
					cnt_reg == 24'(RESET_CYC - 1);
			end

			// Port power
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					port_powered_reg[p] <= 1'b0;
				end else if (!pwr_switched) begin
					// RULE_19: unswitched power always on
					port_powered_reg[p] <= 1'b1;
				end else if (oc_now) begin
					// RULE_14: overcurrent removes power
					port_powered_reg[p] <= 1'b0;
				end else if (pwr_off) begin
					port_powered_reg[p] <= 1'b0;
				end else if (pwr_on) begin
					// RULE_19: set power
					port_powered_reg[p] <= 1'b1;
				end
			end

			// Reset signalling timer
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					st_reg <= RHP_IDLE;
					cnt_reg <= 24'h000000;
				end else if (!port_powered_reg[p]) begin
					// RULE_17: power off drops reset
					st_reg <= RHP_IDLE;
					cnt_reg <= 24'h000000;
				end else begin
					case (st_reg)
						RHP_IDLE: begin
							// RULE_20: start reset if connected
							if (w_rst && conn_now) begin
								st_reg <= RHP_RESETTING;
								cnt_reg <= 24'h000000;
							end
						end
						RHP_RESETTING: begin
							if (rst_end) begin
								st_reg <= RHP_IDLE;
							end else begin
								cnt_reg <= cnt_reg + 24'h000001;
							end
						end
						default: st_reg <= RHP_IDLE;
					endcase
				end
			end

			// Enable and suspend status
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					port_enabled_reg[p] <= 1'b0;
					port_suspended_reg[p] <= 1'b0;
				end else if (!port_powered_reg[p] || !conn_now ||
					line[p].disable_evt) begin
					// RULE_17: clear status without power
					port_enabled_reg[p] <= 1'b0;
					port_suspended_reg[p] <= 1'b0;
				end else begin
					if (rst_end || w_ena) begin
						port_enabled_reg[p] <= 1'b1;
					end
					if (line[p].resume_done || rst_end) begin
						port_suspended_reg[p] <= 1'b0;
					end else if (w_susp && port_enabled_reg[p]) begin
						port_suspended_reg[p] <= 1'b1;
					end
				end
			end

			// Change flags; set wins over write-one clear
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					connect_changed_reg[p] <= 1'b0;
					enable_changed_reg[p] <= 1'b0;
					resume_done_changed_reg[p] <= 1'b0;
					overcurrent_changed_reg[p] <= 1'b0;
					reset_done_changed_reg[p] <= 1'b0;
				end else begin
					// RULE_09: connect change
					// RULE_10: command on empty port
					// RULE_11: fixed device after hub reset
					if ((!fixed_device_flag[p] &&
						conn_now != conn_q_reg[p]) ||
						(!conn_now && (w_rst || w_ena || w_susp)) ||
						(fixed_device_flag[p] && hub_reset_done)) begin
						connect_changed_reg[p] <= 1'b1;
					end else if (wd[`RHP_B_CSC]) begin
						connect_changed_reg[p] <= 1'b0;
					end
					// RULE_08: disable event, disconnect or power loss while enabled
					if (port_enabled_reg[p] && (line[p].disable_evt ||
						!conn_now || !port_powered_reg[p])) begin
						enable_changed_reg[p] <= 1'b1;
					end else if (wd[`RHP_B_ESC]) begin
						enable_changed_reg[p] <= 1'b0;
					end
					// RULE_07: reset done clears resume flag
					// RULE_06: resume sequence complete
					if (rst_end) begin
						resume_done_changed_reg[p] <= 1'b0;
					end else if (line[p].resume_done &&
						port_suspended_reg[p]) begin
						resume_done_changed_reg[p] <= 1'b1;
					end else if (wd[`RHP_B_SSC]) begin
						resume_done_changed_reg[p] <= 1'b0;
					end
					// RULE_05: overcurrent indicator changed
					if (oc_now != oc_q_reg[p]) begin
						overcurrent_changed_reg[p] <= 1'b1;
					end else if (wd[`RHP_B_OCC]) begin
						overcurrent_changed_reg[p] <= 1'b0;
					end
					// RULE_04: reset signalling ended
					if (rst_end) begin
						reset_done_changed_reg[p] <= 1'b1;
					end else if (wd[`RHP_B_RSC]) begin
						reset_done_changed_reg[p] <= 1'b0;
					end
				end
			end

			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					port_reset_out_reg[p] <= 1'b0;
					port_suspend_out_reg[p] <= 1'b0;
					port_power_out_reg[p] <= 1'b0;
				end else begin
					port_reset_out_reg[p] <= st_reg == RHP_RESETTING;
					port_suspend_out_reg[p] <= port_suspended_reg[p];
					port_power_out_reg[p] <= port_powered_reg[p];
				end
			end
		end
	endgenerate

	// RULE_02: status low, change flags high
	// RULE_12: speed valid while connected
	// RULE_21: overcurrent only if per-port
	always_comb begin
		int i;
		i = 0;
		rdata_next = `RHP_RESET_VAL;
		if (req.addr == `RHP_PORT0_OFS) begin
			i = 0;
		end else if (req.addr == `RHP_PORT1_OFS) begin
			i = 1;
		end else begin
			i = 2;
		end
		if (i < 2) begin
			rdata_next[`RHP_B_CONN] = line[i].connected;
			rdata_next[`RHP_B_ENA] = port_enabled_reg[i];
			rdata_next[`RHP_B_SUSP] = port_suspended_reg[i];
			rdata_next[`RHP_B_OCI] = oc_q_reg[i];
			rdata_next[`RHP_B_RST] = port_reset_out_reg[i];
			rdata_next[`RHP_B_PWR] = port_powered_reg[i];
			rdata_next[`RHP_B_SLOW] = line[i].slow & line[i].connected;
			rdata_next[`RHP_B_CSC] = connect_changed_reg[i];
			rdata_next[`RHP_B_ESC] = enable_changed_reg[i];
			rdata_next[`RHP_B_SSC] = resume_done_changed_reg[i];
			rdata_next[`RHP_B_OCC] = overcurrent_changed_reg[i];
			rdata_next[`RHP_B_RSC] = reset_done_changed_reg[i];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= `RHP_RESET_VAL;
		end else if (req.rd) begin
			rdata_reg <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/rhp_checker.sv
/*
 Port-level assertions on rhp_top, port 0.
 Assumes a bind onto rhp_top with its RESET_CYC.
*/
`default_nettype none
module rhp_checker
	import rhp_pkg::*;
#(
	parameter int RESET_CYC = 20
) (
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset
	input wire rhp_req_t req, // Request
	input wire logic [31:0] rdata_reg, // Read data
	input wire logic xact_busy, // Busy
	input wire rhp_line_t [1:0] line, // Line
	input wire logic pwr_switched, // Switched
	input wire logic pwr_mode, // Mode
	input wire logic [1:0] per_port_power_mask, // Mask
	input wire logic [1:0] fixed_device_flag, // Fixed
	input wire logic per_port_oc, // Oc mode
	input wire logic glob_set_pwr, // Set
	input wire logic glob_clr_pwr, // Clear
	input wire logic hub_reset_done, // Hub reset
	input wire logic [1:0] port_reset_out_reg, // Reset out
	input wire logic [1:0] port_suspend_out_reg, // Suspend out
	input wire logic [1:0] port_power_out_reg // Power out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	int hi_cnt;
	wire logic w0 = req.wr && req.addr == 8'h54;
	wire logic pp0 = pwr_mode && per_port_power_mask[0];
	// Length of reset signalling
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			hi_cnt <= 0;
		else
			hi_cnt <= port_reset_out_reg[0] ? hi_cnt + 1 : 0;
	end
	sequence s_clr0;
		w0 && req.wdata[9] && pp0 && !line[0].overcurrent;
	endsequence
	sequence s_held;
		xact_busy ##1 xact_busy[*2];
	endsequence
	AST_CLR_PWR: assert property (s_clr0 ##0 !xact_busy
		|-> ##[1:3] !port_power_out_reg[0]) else $error("no power off");
	AST_DEFER: assert property (s_clr0 ##0 port_power_out_reg[0]
		##0 s_held |-> port_power_out_reg[0]) else $error("not deferred");
	AST_GLOB_ONLY: assert property (w0 && req.wdata[9] && !pwr_mode
		&& port_power_out_reg[0] && !glob_clr_pwr && !line[0].overcurrent
		|=> port_power_out_reg[0][*3]) else $error("port write obeyed");
	AST_OC_OFF: assert property (pwr_switched && line[0].overcurrent
		|-> ##[1:3] !port_power_out_reg[0]) else $error("power kept");
	AST_OFF_CLEAR: assert property ($fell(port_power_out_reg[0])
		|-> ##[0:1] !port_reset_out_reg[0] && !port_suspend_out_reg[0])
		else $error("state kept at power off");
	AST_EMPTY_RST: assert property (w0 && req.wdata[4]
		&& !line[0].connected && !xact_busy
		|=> !port_reset_out_reg[0][*3]) else $error("empty port reset");
	AST_RST_LEN: assert property ($fell(port_reset_out_reg[0])
		|-> hi_cnt >= RESET_CYC - 1 && hi_cnt <= RESET_CYC + 2)
		else $error("reset length");
	AST_RD_LAYOUT: assert property (req.rd && req.addr == 8'h54
		|=> rdata_reg[15:10] == 6'h0 && rdata_reg[31:21] == 11'h0
		&& rdata_reg[0] == $past(line[0].connected)) else $error("layout");
endmodule
`default_nettype wire

// ===== testbench/rhp_dev_model.sv
/*
 Devices on the two ports.
 Assumes the bench drives plug, speed, fault and wake.
*/
`default_nettype none
module rhp_dev_model
	import rhp_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic [1:0] power, // Port power
	input wire logic [1:0] plug, // Plugged
	input wire logic [1:0] slow, // Low speed
	input wire logic [1:0] oc, // Fault
	input wire logic [1:0] wake, // Resume over
	output var rhp_line_t [1:0] line // Line state
);
	logic [1:0] oc_q = 2'h0;
	always_ff @(posedge ref_clk) begin
		oc_q <= oc;
	end
	// Unpowered device looks absent
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			line[i].connected = plug[i] && power[i];
			line[i].slow = slow[i] && plug[i] && power[i];
			line[i].overcurrent = oc[i];
			line[i].disable_evt = oc[i] && !oc_q[i];
			line[i].resume_done = wake[i] && plug[i];
		end
	end
endmodule
`default_nettype wire

// ===== testbench/root_hub_port_status_control_bench.sv
/*
 Self-checking bench for rhp_top.
 Assumes a reset timer shortened to 20 cycles.
*/
`default_nettype none
module root_hub_port_status_control_bench import rhp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RESET_CYC = 20;
	int bad_count = 0;
	int checks = 0;
	logic ref_clk = 0, reset_n = 0, xact_busy = 0, pwr_mode = 1;
	logic glob_set_pwr = 0, glob_clr_pwr = 0;
	logic pwr_sw = 1, per_oc = 1, hub_done = 0;
	logic [1:0] fixed_dev = 2'h0, mask = 2'h3;
	logic [1:0] plug = 0, slow = 0, oc = 0, wake = 0, rst_o, susp_o, pwr_o;
	logic [31:0] rdata_reg, rv;
	rhp_req_t req = '0;
	rhp_line_t [1:0] line;
	`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
		$display("mismatch %0t got %h", $time, (a)); end end
	always #4 ref_clk = ~ref_clk;
	rhp_top #(.RESET_CYC(RESET_CYC)) i_dut (.ref_clk(ref_clk),
		.reset_n(reset_n), .req(req), .rdata_reg(rdata_reg),
		.xact_busy(xact_busy), .line(line), .pwr_switched(pwr_sw),
		.pwr_mode(pwr_mode), .per_port_power_mask(mask),
		.fixed_device_flag(fixed_dev), .per_port_oc(per_oc),
		.glob_set_pwr(glob_set_pwr), .glob_clr_pwr(glob_clr_pwr),
		.hub_reset_done(hub_done), .port_reset_out_reg(rst_o),
		.port_suspend_out_reg(susp_o), .port_power_out_reg(pwr_o));
	rhp_dev_model i_dev (.ref_clk(ref_clk), .power(pwr_o), .plug(plug),
		.slow(slow), .oc(oc), .wake(wake), .line(line));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req <= {1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		req <= {1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		req <= '0;
		@(posedge ref_clk);
		rv = rdata_reg;
	endtask
	task automatic wait_rst();
		int n;
		n = 0;
		// Wait for reset signalling to start, then count its length
		while (rst_o[0] !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		while (rst_o[0] !== 1'b0 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(n, RESET_CYC)
		wr(8'h54, 32'h0);
	endtask
	task automatic t_empty();
		rd(8'h5C);
		`CHK(rv, 32'h0)
		wr(8'h54, 32'h100);
		wr(8'h54, 32'h10);
		rd(8'h54);
		`CHK(rv, 32'h00010100)
		wr(8'h54, 32'h10000);
		plug[0] <= 1'b1;
		slow[0] <= 1'b1;
		rd(8'h54);
		`CHK(rv, 32'h00010301)
		wr(8'h54, 32'h10000);
		rd(8'h54);
		`CHK(rv, 32'h00000301)
	endtask
	task automatic t_reset();
		wr(8'h54, 32'h10);
		wait_rst();
		rd(8'h54);
		`CHK(rv, 32'h00100303)
		wr(8'h54, 32'h00100004);
		wake[0] <= 1'b1;
		@(posedge ref_clk);
		wake[0] <= 1'b0;
		rd(8'h54);
		`CHK(rv[18], 1'b1)
		wr(8'h54, 32'h10);
		wait_rst();
		rd(8'h54);
		`CHK(rv[20:18], 3'b100)
		wr(8'h54, 32'h001C0000);
	endtask
	task automatic t_busy();
		xact_busy <= 1'b1;
		wr(8'h54, 32'h200);
		rd(8'h54);
		`CHK(rv[8], 1'b1)
		xact_busy <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(8'h54);
		`CHK(rv[15:0], 16'h0)
		wr(8'h54, 32'h100);
		wr(8'h54, 32'h200);
		rd(8'h54);
		`CHK(rv[8], 1'b0)
	endtask
	task automatic t_fault();
		wr(8'h54, 32'h100);
		oc[0] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(8'h54);
		`CHK({rv[19], rv[8], rv[3]}, 3'b101)
		oc[0] <= 1'b0;
		pwr_mode <= 1'b0;
		wr(8'h54, 32'h100);
		rd(8'h54);
		`CHK(rv[8], 1'b0)
		glob_set_pwr <= 1'b1;
		@(posedge ref_clk);
		glob_set_pwr <= 1'b0;
		wr(8'h54, 32'h200);
		rd(8'h54);
		`CHK(rv[8], 1'b1)
		glob_clr_pwr <= 1'b1;
		@(posedge ref_clk);
		glob_clr_pwr <= 1'b0;
		pwr_mode <= 1'b1;
		wr(8'h58, 32'h100);
		rd(8'h58);
		`CHK(rv, 32'h00000100)
	endtask
	task automatic t_misc();
		fixed_dev <= 2'h2;
		plug[1] <= 1'b1;
		rd(8'h58);
		`CHK(rv[16], 1'b0)
		hub_done <= 1'b1;
		@(posedge ref_clk);
		hub_done <= 1'b0;
		rd(8'h58);
		`CHK(rv[16], 1'b1)
		wr(8'h58, 32'h2);
		rd(8'h58);
		`CHK({rv[17], rv[1]}, 2'b01)
		oc[1] <= 1'b1;
		@(posedge ref_clk);
		oc[1] <= 1'b0;
		rd(8'h58);
		`CHK({rv[19], rv[17]}, 2'b11)
		mask <= 2'h1;
		wr(8'h58, 32'h100);
		rd(8'h58);
		`CHK(rv[8], 1'b0)
		mask <= 2'h3;
		per_oc <= 1'b0;
		oc[0] <= 1'b1;
		rd(8'h54);
		`CHK(rv[3], 1'b0)
		oc[0] <= 1'b0;
		per_oc <= 1'b1;
		pwr_sw <= 1'b0;
		rd(8'h54);
		`CHK(rv[8], 1'b1)
		pwr_sw <= 1'b1;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_empty();
		t_reset();
		t_busy();
		t_fault();
		t_misc();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
endmodule
bind rhp_top rhp_checker #(.RESET_CYC(RESET_CYC)) i_chk (.*);
`default_nettype wire
